/* File: common/bdt_regs.vh */
`ifndef BDT_REGS_VH
`define BDT_REGS_VH
// Primary opcodes
`define BDT_OPC_UNCOND 6'h12
`define BDT_OPC_COND 6'h10
// Hint codes of the newer encoding
`define BDT_HINT_NONE 2'h0
`define BDT_HINT_RSVD 2'h1
`define BDT_HINT_NOT_TAKEN 2'h2
`define BDT_HINT_TAKEN 2'h3
// Predict codes on the predict output
`define BDT_PRED_NONE 2'h0
`define BDT_PRED_NOT_TAKEN 2'h2
`define BDT_PRED_TAKEN 2'h3
// Reset values
`define BDT_RESET_WORD 32'h00000000
`endif

/* File: src/bdt_branch_decode.v */
// Functional notes
// - Opcode 18 is unconditional; displacement bits 6-29, absolute bit 30, link bit 31.
// - Relative unconditional target is sign-extended displacement times four plus own address.
// - Absolute unconditional target is sign-extended displacement times four, no address added.
// - Target method comes only from the absolute bit of the word.
// - Link bit set loads link register with next instruction address; else unchanged.
// - Neither branch alters the exception register or condition field zero.
// - Opcode 16 is conditional; option, bit index, displacement, absolute, link fields.
// - Relative conditional target is sign-extended 14-bit displacement times four plus address.
// - Absolute conditional target is sign-extended 14-bit displacement times four.
// - Bit index picks the one condition register bit tested.
// - Options 0000y/0001y decrement count; branch if condition false and count nonzero/zero.
// - Options 0100y/0101y decrement count; branch if condition true and count nonzero/zero.
// - 001zy branches on false, 011zy on true, count untouched; 1z1zz always.
// - 1z00y/1z01y decrement count; branch on nonzero/zero count, condition ignored.
// - Newer mode flags any nonzero z position as an invalid form.
// - Older y position is a prediction hint only, default zero.
// - Older family mode accepts any z and y values without flagging.
// - Newer a and t positions carry hints only; outcomes unchanged.
// - Hint 00 none, 01 reserved, 10 likely not taken, 11 likely taken.
`include "bdt_regs.vh"
`timescale 1ns/1ps
`default_nettype none

module bdt_branch_decode (
  input wire ref_clk,
  input wire rstn,
  input wire instValid,
  input wire [31:0] instWord,
  input wire [31:0] instAddr,
  input wire [31:0] condReg,
  input wire newerMode,
  output reg resultValid,
  output reg isBranch,
  output reg branchTaken,
  output reg [31:0] targetAddr,
  output reg linkWrite,
  output reg [31:0] linkValue,
  output reg invalidForm,
  output reg [1:0] predictHint,
  output reg [31:0] loopCountRegister
);

  // Field bit 0 is the MSB of instWord

  // Sign-extend a displacement and append two zero bits
  function [31:0] sext_disp;
    input [23:0] disp;
    input isShort;
    begin
      if (isShort) begin
        sext_disp = {{16{disp[13]}}, disp[13:0], 2'h0};
      end else begin
        sext_disp = {{6{disp[23]}}, disp, 2'h0};
      end
    end
  endfunction

  // Count test for the decrementing options
  function count_ok;
    input zeroWanted;
    input isZero;
    begin
      count_ok = zeroWanted ? isZero : ~isZero;
    end
  endfunction

  // Hint as reported; reserved code shows as none
  function [1:0] hint_clean;
    input [1:0] code;
    begin
      if (code == `BDT_HINT_RSVD) begin
        hint_clean = `BDT_PRED_NONE;
      end else begin
        hint_clean = code;
      end
    end
  endfunction

  wire [5:0] opcode;
  wire uncond;
  wire cond;
  wire eitherBranch;
  wire absoluteSelect;
  wire linkSelect;
  wire [23:0] wordOffsetField;
  wire [4:0] branchOptionField;
  wire [4:0] conditionBitIndex;
  wire [13:0] shortDisplacement;
  wire [4:0] crPos;
  wire condBit;
  wire [31:0] countDec;
  wire countZero;
  wire [31:0] dispExt;
  wire [31:0] relTarget;
  wire [31:0] nextAddr;
  wire effectOk;

  assign opcode = instWord[31:26];
  assign uncond = instValid & (opcode == `BDT_OPC_UNCOND);
  assign wordOffsetField = instWord[25:2];

  assign cond = instValid & (opcode == `BDT_OPC_COND);
  assign branchOptionField = instWord[25:21];
  assign conditionBitIndex = instWord[20:16];
  assign shortDisplacement = instWord[15:2];

  // Bits shared by both forms
  assign absoluteSelect = instWord[1];
  assign linkSelect = instWord[0];
  assign eitherBranch = uncond | cond;

  // bit index counts from the MSB
  assign crPos = 5'h1f - conditionBitIndex;
  assign condBit = condReg[crPos];

  // Decremented count and its zero test
  assign countDec = loopCountRegister - 32'h00000001; // Wraps from zero
  assign countZero = (countDec == 32'h00000000);

  assign dispExt = uncond ? sext_disp(wordOffsetField, 1'b0)
                          : sext_disp({10'h000, shortDisplacement}, 1'b1);
  assign relTarget = dispExt + instAddr;
  assign nextAddr = instAddr + 32'h00000004;

  // Decode results of the option field
  reg decDo;
  reg takeD;
  reg zBad;
  reg [1:0] hintD;

  // Taken decision per option pattern
  always @* begin
    takeD = 1'b0;
    case (branchOptionField[4:2])
      3'h0: begin
        takeD = ~condBit & count_ok(branchOptionField[1], countZero);
      end
      3'h2: begin
        takeD = condBit & count_ok(branchOptionField[1], countZero);
      end
      3'h1: begin
        takeD = ~condBit;
      end
      3'h3: begin
        takeD = condBit;
      end
      3'h4, 3'h6: begin
        takeD = count_ok(branchOptionField[1], countZero);
      end
      3'h5, 3'h7: begin
        takeD = 1'b1;
      end
      default: begin
        takeD = 1'b0;
      end
    endcase
  end

  always @* begin
    decDo = ~branchOptionField[2];
  end

  // reserved z positions in newer mode
  always @* begin
    zBad = 1'b0;
    if (newerMode) begin
      if (~branchOptionField[4] & ~branchOptionField[2]) begin
        zBad = branchOptionField[0];
      end else if (branchOptionField[4] & branchOptionField[2]) begin
        zBad = branchOptionField[3] | branchOptionField[1] | branchOptionField[0];
      end
    end
  end

  // Prediction hint per encoding
  always @* begin
    hintD = `BDT_PRED_NONE;
    if (newerMode) begin
      // a and t carry hints only
      if (branchOptionField[4] & ~branchOptionField[2]) begin
        hintD = hint_clean({branchOptionField[3], branchOptionField[0]});
      end else if (~branchOptionField[4] & branchOptionField[2]) begin
        hintD = hint_clean(branchOptionField[1:0]);
      end
    end else begin
      if (~(branchOptionField[4] & branchOptionField[2]) & branchOptionField[0]) begin
        hintD = `BDT_PRED_TAKEN;
      end
    end
  end

  // Effects allowed: unconditional, or a well-formed conditional
  // Refused forms have no link and no count effect
  assign effectOk = uncond | (cond & ~zBad);

  // Answer strobe one cycle after each fetch
  always @(posedge ref_clk) begin
    if (!rstn) begin
      resultValid <= 1'b0;
    end else begin
      resultValid <= instValid;
    end
  end

  // Branch kind of the answered word
  always @(posedge ref_clk) begin
    if (!rstn) begin
      isBranch <= 1'b0;
    end else begin
      isBranch <= eitherBranch;
    end
  end

  // Taken outcome; refused forms never branch
  always @(posedge ref_clk) begin
    if (!rstn) begin
      branchTaken <= 1'b0;
    end else begin
      branchTaken <= uncond | (cond & takeD & ~zBad);
    end
  end

  // absolute bit alone picks the method
  always @(posedge ref_clk) begin
    if (!rstn) begin
      targetAddr <= `BDT_RESET_WORD;
    end else if (absoluteSelect) begin
      targetAddr <= dispExt;
    end else begin
      targetAddr <= relTarget;
    end
  end

  always @(posedge ref_clk) begin
    if (!rstn) begin
      linkWrite <= 1'b0;
    end else begin
      linkWrite <= effectOk & linkSelect;
    end
  end

  // Link value holds until the next linking branch
  always @(posedge ref_clk) begin
    if (!rstn) begin
      linkValue <= `BDT_RESET_WORD;
    end else if (effectOk & linkSelect) begin
      linkValue <= nextAddr;
    end
  end

  // Refused form strobe
  always @(posedge ref_clk) begin
    if (!rstn) begin
      invalidForm <= 1'b0;
    end else begin
      invalidForm <= cond & zBad;
    end
  end

  // Hint only for conditional words
  always @(posedge ref_clk) begin
    if (!rstn) begin
      predictHint <= `BDT_PRED_NONE;
    end else if (cond) begin
      predictHint <= hintD;
    end else begin
      predictHint <= `BDT_PRED_NONE;
    end
  end

  // only link and count change state
  // Count steps on well-formed counting patterns
  always @(posedge ref_clk) begin
    if (!rstn) begin
      loopCountRegister <= `BDT_RESET_WORD;
    end else if (cond & decDo & ~zBad) begin
      loopCountRegister <= countDec;
    end
  end

endmodule // bdt_branch_decode

`default_nettype wire

/* File: tb/bdt_chk_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module bdt_chk (
  input wire ref_clk,
  input wire rstn,
  input wire instValid,
  input wire [31:0] instWord,
  input wire [31:0] instAddr,
  input wire newerMode,
  input wire resultValid,
  input wire branchTaken,
  input wire isBranch,
  input wire [31:0] targetAddr,
  input wire linkWrite,
  input wire [31:0] linkValue,
  input wire invalidForm,
  input wire [1:0] predictHint,
  input wire [31:0] loopCountRegister
);
  // Decode terms and expected target
  wire un = instValid && instWord[31:26] == 6'h12;
  wire co = instValid && instWord[31:26] == 6'h10 && !newerMode;
  wire [31:0] tgt = (instWord[1] ? 32'h0 : instAddr) + (un ?
    {{6{instWord[25]}}, instWord[25:2], 2'h0} : {{16{instWord[15]}}, instWord[15:2], 2'h0});
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  a_answer_next: assert property (instValid |=> resultValid) else $error("no answer");
  a_idle_quiet: assert property (!instValid |=> !resultValid && $stable(loopCountRegister))
    else $error("idle change");
  a_target_calc: assert property (un || co |=> isBranch && targetAddr == $past(tgt))
    else $error("bad target");
  a_uncond_taken: assert property (un |=> branchTaken && !invalidForm) else $error("not taken");
  a_link_value: assert property (un && instWord[0] |=> linkWrite && linkValue == $past(instAddr) + 32'h4)
    else $error("bad link");
  a_older_valid: assert property (co |=> !invalidForm) else $error("flagged");
  a_always_taken: assert property (co && instWord[25] && instWord[23] |=> branchTaken)
    else $error("not always");
  a_count_step: assert property (co && !instWord[23] |=> loopCountRegister == $past(loopCountRegister) - 32'h1)
    else $error("bad count");
  a_hint_taken: assert property (instValid && newerMode && instWord[31:21] == 11'h20f |=> predictHint == 2'h3)
    else $error("bad hint");
  a_refuse_quiet: assert property (invalidForm |-> !branchTaken && !linkWrite)
    else $error("refused form acted");
  c_link: cover property (un && instWord[0]);
  c_hint: cover property (predictHint == 2'h3);
  c_count: cover property (co && !instWord[23]);
  c_refused: cover property (invalidForm);
endmodule // bdt_chk
bind bdt_branch_decode bdt_chk chk (.*);
`default_nettype wire

/* File: tb/bdt_fetch_model.sv */
`timescale 1ns/1ps
`default_nettype none
module bdt_fetch_model (
  input wire ref_clk,
  input wire [97:0] req,
  output logic instValid,
  output logic [31:0] instWord,
  output logic [31:0] instAddr,
  output logic [31:0] condReg,
  output logic newerMode
);
  // Present each fetch on the falling edge
  initial {instValid, instWord, instAddr, condReg, newerMode} = 98'h0;
  always @(negedge ref_clk) {instValid, instWord, instAddr, condReg, newerMode} <= req;
endmodule // bdt_fetch_model
`default_nettype wire

/* File: tb/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic [97:0] req = 98'h0;
  logic instValid, newerMode, resultValid, isBranch, branchTaken, linkWrite, invalidForm;
  logic [31:0] instWord, instAddr, condReg, targetAddr, linkValue, loopCountRegister;
  logic [1:0] predictHint;
  logic [101:0] expQ[$];
  logic [31:0] cnt = 32'h0;
  logic [31:0] lv = 32'h0;
  integer seed = 30190;
  integer bad_count = 0;
  integer n_tests = 0;
  integer i;
  wire [101:0] seen = {isBranch, branchTaken, linkWrite, invalidForm, predictHint, targetAddr,
    loopCountRegister, linkValue};
  // Clock, fetch partner and decoder
  always #12.5 ref_clk = ~ref_clk;
  bdt_fetch_model fm (.*);
  bdt_branch_decode dut (.*);
  // Expected answer of one fetch, advancing the count model
  function automatic logic [101:0] predict(input logic [97:0] r);
    logic [31:0] w, t;
    logic [4:0] b;
    logic [1:0] h;
    logic br, tk, iv;
    begin
      w = r[96:65];
      b = w[25:21];
      t = w[1] ? 32'h0 : r[64:33];
      br = w[31:26] == 6'h12 || w[31:26] == 6'h10;
      iv = 1'b0;
      tk = br;
      t = t + {{6{w[25]}}, w[25:2], 2'h0};
      if (w[31:26] == 6'h10) begin
        iv = r[0] && (b[4] && b[2] ? |{b[3], b[1], b[0]} : !b[4] && !b[2] && b[0]);
        if (!iv && !b[2]) cnt = cnt - 32'h1;
        tk = !iv && (b[2] || (cnt == 32'h0) == b[1]) && (b[4] || r[32 - w[20:16]] == b[3]);
        t = (w[1] ? 32'h0 : r[64:33]) + {{16{w[15]}}, w[15:2], 2'h0};
      end
      h = 2'h0;
      // hint as reported, reserved shown as none
      if (w[31:26] == 6'h10 && r[0] && b[4] && !b[2]) h = {b[3], b[0]};
      if (w[31:26] == 6'h10 && r[0] && !b[4] && b[2]) h = b[1:0];
      if (w[31:26] == 6'h10 && !r[0] && !(b[4] && b[2]) && b[0]) h = 2'h3;
      if (h == 2'h1) h = 2'h0;
      if (br && w[0] && !iv) lv = r[64:33] + 32'h4;
      predict = {br, tk, br && w[0] && !iv, iv, h, t, cnt, lv};
    end
  endfunction
  // Compare one answer; target ignored for non-branches and refused forms
  task automatic check(input logic [101:0] x, input logic [101:0] g);
    n_tests = n_tests + 1;
    if (((x ^ g) & {6'h3f, {32{x[101] & ~x[98]}}, 64'hffffffffffffffff}) !== 102'h0) begin
      bad_count = bad_count + 1;
      $display("[FAIL] answer exp %h got %h", x, g);
    end
  endtask
  // Match each answer with the oldest note
  always @(negedge ref_clk) if (resultValid === 1'b1) check(expQ.size() ? expQ.pop_front() : 102'hx, seen);
  task automatic stop_test;
    $display("compares %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Random mix of both branch kinds, other opcodes and idle slots
  initial begin
    repeat (16) @(negedge ref_clk);
    rstn = 1'b1;
    for (i = 0; i < 400; i = i + 1) begin
      @(posedge ref_clk);
      req = {$random(seed), $random(seed), $random(seed), $random(seed)};
      req[97] = req[97] | i[2];
      if (i[1:0] != 2'h3) req[96:91] = i[1:0] == 2'h0 ? 6'h12 : 6'h10;
      // every 32nd fetch is opcode 16, option 01111, in newer mode: hint taken
      if (i[4:0] == 5'h1f) req[96:86] = 11'h20f;
      if (i[4:0] == 5'h1f) req[0] = 1'b1;
      if (req[97]) expQ.push_back(predict(req));
    end
    @(posedge ref_clk);
    req[97] = 1'b0;
    for (i = 0; i < 8 && expQ.size() > 0; i = i + 1) @(posedge ref_clk);
    if (expQ.size() > 0) bad_count = bad_count + 1;
    $display("test random_mix done");
    stop_test();
  end
endmodule // tb_top
`default_nettype wire
